// >>> core/mbm_buf.sv
/*
  Two-entry word buffer with valid and ready on both sides, so a
  stall by the reader loses no word. Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module mbm_buf (
  input  wire logic   clock,
  input  wire logic   rst,
  mbm_word_if.sink    wi,
  mbm_word_if.source  wo
);

  mbm_pkg::mbm_buf_type q;
  mbm_pkg::mbm_buf_type next_q;
  logic                 push;
  logic                 pop;

  ////////////////////////////////////////////////////////////////////
  // Handshakes and next state
  always_comb begin
    wi.ready = (q.cnt != 2'h2);
    wo.valid = (q.cnt != 2'h0);
    wo.data  = q.d[0];
    push     = wi.valid && wi.ready;
    pop      = wo.valid && wo.ready;
    next_q   = q;
    if (pop) begin
      next_q.d[0] = q.d[1];
    end
    if (push) begin
      next_q.d[(pop ? q.cnt - 2'h1 : q.cnt) == 2'h0 ? 0 : 1] = wi.data;
    end
    next_q.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  property p_full_stalls;
    @(posedge clock) disable iff (rst)
      (wo.valid && !wo.ready) [*2] ##0 $past(wi.valid && wi.ready) |-> !wi.ready;
  endproperty
  a_full_stalls: assert property (p_full_stalls) else $error("full buffer took word");

endmodule // mbm_buf

`default_nettype wire

// >>> core/mbm_check.sv
/*
  Frame check unit: running byte sum for the text mode check and
  reflected CRC-16 for the binary mode. Assumes one byte per upd pulse.
*/
`timescale 1ns/1ps
`include "mbm_defines.svh"
`default_nettype none

module mbm_check (
  input  wire logic clock,
  input  wire logic rst,
  mbm_chk_if.unit   chk
);

  mbm_pkg::mbm_chk_type q;
  mbm_pkg::mbm_chk_type next_q;

  // One byte through the reflected generator, low bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBM_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_q = q;
    if (chk.clr) begin
      next_q.sum = 8'h00;
      next_q.crc = `MBM_CRC_INIT;
    end else if (chk.upd) begin
      next_q.sum = q.sum + chk.data;                    // Carry dropped
      next_q.crc = crc_byte(q.crc, chk.data);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q <= '{sum: 8'h00, crc: `MBM_CRC_INIT};
    end else begin
      q <= next_q;
    end
  end

  assign chk.sum = q.sum;
  assign chk.crc = q.crc;

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_seed;
    @(posedge clock) disable iff (rst)
      chk.clr |=> (chk.crc == 16'hFFFF) && (chk.sum == 8'h00);
  endproperty
  a_seed: assert property (p_seed) else $error("check seed wrong");

  property p_crc_step;
    @(posedge clock) disable iff (rst)
      (chk.upd && !chk.clr && chk.crc == 16'hFFFF && chk.data == 8'h11)
        |=> chk.crc == 16'h4C7F;
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("crc step wrong");

endmodule // mbm_check

`default_nettype wire

// >>> core/mbm_defines.svh
/*
  Constants of the serial bus master: character codes, function codes,
  check seeds and timing counts. Assumes a 200 MHz system clock.
*/
`ifndef MBM_DEFINES_SVH
`define MBM_DEFINES_SVH

// Clock and line timing
`define MBM_CLK_HZ        64'd200000000
`define MBM_BAUD          64'd9600
`define MBM_ASCII_GAP_S   64'd1
`define MBM_RTU_GAP_BITS  64'd24
`define MBM_RESP_S        64'd1
`define MBM_TMR_W         28
`define MBM_ASCII_GAP_CYC (`MBM_ASCII_GAP_S * `MBM_CLK_HZ)
`define MBM_RTU_GAP_CYC   ((`MBM_RTU_GAP_BITS * `MBM_CLK_HZ) / `MBM_BAUD)
`define MBM_RESP_CYC      (`MBM_RESP_S * `MBM_CLK_HZ)

// Framing characters
`define MBM_CH_COLON      8'h3A
`define MBM_CH_CR         8'h0D
`define MBM_CH_LF         8'h0A

// Function codes and field limits
`define MBM_FC_READ       8'h03
`define MBM_FC_WRITE1     8'h06
`define MBM_FC_LOOP       8'h08
`define MBM_FC_WRITEN     8'h10
`define MBM_EXC_BIT       7
`define MBM_ADDR_MIN      8'h01
`define MBM_ADDR_MAX      8'hF7
`define MBM_HDR_BYTES     8'h06
`define MBM_MIN_REPLY     8'h04

// Check seed and polynomial
`define MBM_CRC_INIT      16'hFFFF
`define MBM_CRC_POLY      16'hA001

`endif

// >>> core/mbm_if.sv
/*
  Internal carriers: a word stream with valid and ready, and the
  link to the frame check unit. Used only between the master's modules.
*/
`timescale 1ns/1ps
`default_nettype none

interface mbm_word_if;
  logic        valid;
  logic        ready;
  logic [15:0] data;
  modport sink   (input valid, input data, output ready);
  modport source (output valid, output data, input ready);
endinterface // mbm_word_if

interface mbm_chk_if;
  logic        clr;
  logic        upd;
  logic [7:0]  data;
  logic [7:0]  sum;
  logic [15:0] crc;
  modport unit (input clr, input upd, input data, output sum, output crc);
  modport user (output clr, output upd, output data, input sum, input crc);
endinterface // mbm_chk_if

`default_nettype wire

// >>> core/mbm_master.sv
/*
  Serial bus master: builds request frames in text (ASCII) or binary
  (RTU) mode, sends them as a character stream, and parses the reply.
  Assumes an outside UART moves characters; all inputs synchronous.
*/
`timescale 1ns/1ps
`include "mbm_defines.svh"
`default_nettype none

module mbm_master #(
  parameter logic [`MBM_TMR_W-1:0] RESP_CYC      = `MBM_TMR_W'(`MBM_RESP_CYC),
  parameter logic [`MBM_TMR_W-1:0] ASCII_GAP_CYC = `MBM_TMR_W'(`MBM_ASCII_GAP_CYC),
  parameter logic [`MBM_TMR_W-1:0] RTU_GAP_CYC   = `MBM_TMR_W'(`MBM_RTU_GAP_CYC)
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic        cmd_ascii,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [7:0]  cmd_func,
  input  wire logic [15:0] cmd_reg,
  input  wire logic [15:0] cmd_cnt,
  input  wire logic        wr_valid,
  output logic             wr_ready,
  input  wire logic [15:0] wr_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [7:0]  rx_data,
  output logic             rsp_valid,
  input  wire logic        rsp_ready,
  output logic [15:0]      rsp_data,
  output logic             done,
  output logic             fail_check,
  output logic             fail_addr,
  output logic             fail_timeout,
  output logic             exception,
  output logic [7:0]       exc_code
);

  mbm_pkg::mbm_main_type q;
  mbm_pkg::mbm_main_type next_q;
  mbm_chk_if             chk ();
  mbm_word_if            wq ();
  mbm_word_if            rq ();
  logic [7:0]            plen;
  logic [7:0]            tb;
  logic                  tb_ok;
  logic                  fire;
  logic                  bdone;
  logic [7:0]            rc;
  logic [7:0]            rbyte;
  logic                  rdone;
  logic                  push;
  logic                  finish;
  logic                  bad_chk;
  logic [7:0]            dix;

  // Nibble to upper-case hex character
  function automatic logic [7:0] hexchar(input logic [3:0] n);
    return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  // Hex character to nibble, either case
  function automatic logic [3:0] hexval(input logic [7:0] c);
    return c[6] ? (c[3:0] + 4'h9) : c[3:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Sub-blocks
  mbm_check u_check (
    .clock (clock),
    .rst   (rst),
    .chk   (chk.unit)
  );

  mbm_buf u_buf (
    .clock (clock),
    .rst   (rst),
    .wi    (wq.sink),
    .wo    (rq.source)
  );

  assign rsp_valid    = rq.valid;
  assign rsp_data     = rq.data;
  assign rq.ready     = rsp_ready;
  assign done         = q.done;
  assign fail_check   = q.f_chk;
  assign fail_addr    = q.f_addr;
  assign fail_timeout = q.f_tmo;
  assign exception    = q.f_exc;
  assign exc_code     = q.ecode;

  ////////////////////////////////////////////////////////////////////
  // Request byte at the current index
  always_comb begin
    plen = (q.func == `MBM_FC_WRITEN) ? (8'h07 + {q.cnt[6:0], 1'b0}) : `MBM_HDR_BYTES;
    tb_ok = 1'b1;
    unique case (q.idx)                                 // Same field order for every code
      8'h00:   tb = q.addr;
      8'h01:   tb = q.func;
      8'h02:   tb = q.regn[15:8];
      8'h03:   tb = q.regn[7:0];
      8'h04:   tb = q.cnt[15:8];
      8'h05:   tb = q.cnt[7:0];
      8'h06:   tb = {q.cnt[6:0], 1'b0};                 // Byte count of values
      default: begin
        tb    = q.idx[0] ? q.wbuf[15:8] : q.wbuf[7:0];
        tb_ok = q.have;
      end
    endcase
    if (q.st == mbm_pkg::s_chk) begin
      tb = q.ascii ? (8'h00 - chk.sum) :
           (q.k ? chk.crc[15:8] : chk.crc[7:0]);        // Low byte first
      tb_ok = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reply character and byte assembly
  always_comb begin
    rc      = q.ascii ? {1'b0, rx_data[6:0]} : rx_data;
    rbyte   = q.ascii ? {q.hinib, hexval(rc)} : rc;     // Two chars per byte
    rdone   = 1'b0;
    dix     = q.ri - 8'h03;
    if (rx_valid) begin
      if (q.st == mbm_pkg::s_rwait) begin
        rdone = !q.ascii;
      end else if (q.st == mbm_pkg::s_rbody) begin
        rdone = !q.ascii || (rc != `MBM_CH_CR && q.nib);
      end
    end
    // Read data words inside the byte count go to the buffer
    push     = rdone && q.ri >= 8'h03 && q.func == `MBM_FC_READ && !q.exc &&
               dix < q.bcnt && dix[0];
    rx_ready = !(push && !wq.ready);
    bad_chk  = q.ascii ? (chk.sum != 8'h00) :
               ((chk.crc != 16'h0000) || q.ri < `MBM_MIN_REPLY);
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequencer
  always_comb begin
    next_q     = q;
    next_q.done = 1'b0;
    cmd_ready  = (q.st == mbm_pkg::s_idle);
    wr_ready   = 1'b0;
    tx_valid   = 1'b0;
    tx_data    = 8'h00;
    chk.clr    = 1'b0;
    chk.upd    = 1'b0;
    chk.data   = rbyte;
    wq.valid   = push;
    wq.data    = {q.hib, rbyte};
    finish     = 1'b0;
    fire       = 1'b0;
    bdone      = 1'b0;
    // Body and check characters, two per byte in text mode
    if (q.st == mbm_pkg::s_body || q.st == mbm_pkg::s_chk) begin
      tx_valid = tb_ok;
      tx_data  = !q.ascii ? tb : hexchar(q.nib ? tb[3:0] : tb[7:4]);
      fire     = tx_valid && tx_ready;                  // Sent back to back
      bdone    = fire && (!q.ascii || q.nib);
      if (fire && q.ascii) begin
        next_q.nib = !q.nib;
      end
    end
    unique case (q.st)
      mbm_pkg::s_idle: begin
        if (cmd_valid) begin
          next_q.f_chk  = 1'b0;
          next_q.f_addr = 1'b0;
          next_q.f_tmo  = 1'b0;
          next_q.f_exc  = 1'b0;
          next_q.ecode  = 8'h00;
          if (cmd_addr < `MBM_ADDR_MIN || cmd_addr > `MBM_ADDR_MAX) begin
            next_q.done   = 1'b1;                       // Refused, nothing sent
            next_q.f_addr = 1'b1;
          end else begin
            next_q.ascii = cmd_ascii;
            next_q.addr  = cmd_addr;
            next_q.func  = cmd_func;
            next_q.regn  = cmd_reg - 16'h0001;          // Offset by one
            next_q.cnt   = cmd_cnt;
            next_q.idx   = 8'h00;
            next_q.nib   = 1'b0;
            next_q.have  = 1'b0;
            next_q.st    = cmd_ascii ? mbm_pkg::s_sof : mbm_pkg::s_body;
            chk.clr      = 1'b1;
          end
        end
      end
      mbm_pkg::s_sof: begin
        tx_valid = 1'b1;
        tx_data  = `MBM_CH_COLON;
        if (tx_ready) begin
          next_q.st = mbm_pkg::s_body;
        end
      end
      mbm_pkg::s_body: begin
        if (q.idx >= 8'h07 && q.idx[0] && !q.have) begin
          wr_ready = 1'b1;
          if (wr_valid) begin
            next_q.wbuf = wr_data;
            next_q.have = 1'b1;
          end
        end
        if (bdone) begin
          chk.upd  = 1'b1;
          chk.data = tb;                                // Eight data bits only
          next_q.idx = q.idx + 8'h01;
          if (q.idx >= 8'h08 && !q.idx[0]) begin
            next_q.have = 1'b0;
          end
          if (q.idx == plen - 8'h01) begin
            next_q.st = mbm_pkg::s_chk;
            next_q.k  = 1'b0;
          end
        end
      end
      mbm_pkg::s_chk: begin
        if (bdone) begin
          next_q.k = 1'b1;
          if (q.ascii) begin
            next_q.st = mbm_pkg::s_cr;
          end else if (q.k) begin
            next_q.st = mbm_pkg::s_rwait;
            chk.clr   = 1'b1;                           // Reply check starts fresh
          end
        end
      end
      mbm_pkg::s_cr: begin
        tx_valid = 1'b1;
        tx_data  = `MBM_CH_CR;
        if (tx_ready) begin
          next_q.st = mbm_pkg::s_lf;
        end
      end
      mbm_pkg::s_lf: begin
        tx_valid = 1'b1;
        tx_data  = `MBM_CH_LF;
        if (tx_ready) begin
          next_q.st = mbm_pkg::s_rwait;
          chk.clr   = 1'b1;                             // Reply sum starts fresh
        end
      end
      mbm_pkg::s_rwait: begin
        if (rx_valid && q.ascii && rc == `MBM_CH_COLON) begin
          next_q.st  = mbm_pkg::s_rbody;
          next_q.nib = 1'b0;
        end else if (rdone) begin
          next_q.st = mbm_pkg::s_rbody;
        end else if (q.timer >= RESP_CYC) begin
          finish       = 1'b1;
          next_q.f_tmo = 1'b1;
        end
      end
      mbm_pkg::s_rbody: begin
        if (rx_valid && q.ascii) begin
          if (rc == `MBM_CH_CR) begin
            next_q.st = mbm_pkg::s_rlf;
          end else if (!q.nib) begin
            next_q.hinib = hexval(rc);
            next_q.nib   = 1'b1;
          end else if (rx_ready) begin
            next_q.nib = 1'b0;
          end
        end else if (q.ascii && q.timer >= ASCII_GAP_CYC) begin
          finish       = 1'b1;                          // Stalled text frame
          next_q.f_tmo = 1'b1;
        end else if (!q.ascii && !rx_valid && q.timer >= RTU_GAP_CYC) begin
          finish = 1'b1;                                // Silence ends frame
        end
      end
      mbm_pkg::s_rlf: begin
        if (rx_valid) begin
          finish = 1'b1;
        end else if (q.timer >= ASCII_GAP_CYC) begin
          finish       = 1'b1;
          next_q.f_tmo = 1'b1;
        end
      end
      default: next_q.st = mbm_pkg::s_idle;
    endcase
    // Reply bytes: address, code, count or error code, data
    if (rdone && rx_ready) begin
      chk.upd = 1'b1;
      next_q.ri = (q.ri == 8'hFF) ? q.ri : q.ri + 8'h01;
      unique case (q.ri)
        8'h00:   next_q.abad = (rbyte != q.addr);
        8'h01:   next_q.exc  = rbyte[`MBM_EXC_BIT];
        8'h02:   begin
          next_q.bcnt = rbyte;
          if (q.exc) begin
            next_q.ecode = rbyte;
          end
        end
        default: next_q.hib = rbyte;
      endcase
    end
    if (q.st == mbm_pkg::s_rwait || q.st == mbm_pkg::s_rbody || q.st == mbm_pkg::s_rlf) begin
      next_q.timer = (rx_valid && rx_ready) ? '0 : q.timer + 1'b1;
    end else begin
      next_q.timer = '0;
      next_q.ri    = 8'h00;
      next_q.exc   = 1'b0;
      next_q.abad  = 1'b0;
    end
    // Close the reply: a failed check masks the address and exception flags
    if (finish) begin
      next_q.st     = mbm_pkg::s_idle;
      next_q.done   = 1'b1;
      next_q.f_chk  = !next_q.f_tmo && bad_chk;
      next_q.f_addr = !next_q.f_tmo && !bad_chk && q.abad;
      next_q.f_exc  = !next_q.f_tmo && !bad_chk && q.exc;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      q    <= '0;
      q.st <= mbm_pkg::s_idle;
    end else begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_colon;
    @(posedge clock) disable iff (rst)
      (q.st == mbm_pkg::s_sof) |-> q.ascii && tx_valid && tx_data == 8'h3A;
  endproperty
  a_colon: assert property (p_colon) else $error("bad frame start");

  property p_crlf;
    @(posedge clock) disable iff (rst)
      (tx_valid && tx_ready && q.st == mbm_pkg::s_cr)
        |=> tx_valid && tx_data == 8'h0A ##0 (q.st == mbm_pkg::s_lf);
  endproperty
  a_crlf: assert property (p_crlf) else $error("CR not followed by LF");

  property p_hex;
    @(posedge clock) disable iff (rst)
      (q.ascii && tx_valid && (q.st == mbm_pkg::s_body || q.st == mbm_pkg::s_chk))
        |-> tx_data inside {[8'h30:8'h39], [8'h41:8'h46]};
  endproperty
  a_hex: assert property (p_hex) else $error("non-hex text char");

  property p_crc_lo_first;
    @(posedge clock) disable iff (rst)
      (q.st == mbm_pkg::s_chk && !q.ascii && !q.k && tx_valid && tx_ready)
        |=> tx_valid && tx_data == $past(chk.crc[15:8]);
  endproperty
  a_crc_lo_first: assert property (p_crc_lo_first) else $error("crc order");

  property p_lrc_fail;
    @(posedge clock) disable iff (rst)
      (q.st == mbm_pkg::s_rlf && rx_valid && chk.sum != 8'h00) |=> done && fail_check;
  endproperty
  a_lrc_fail: assert property (p_lrc_fail) else $error("bad LRC accepted");

  property p_addr_refuse;
    @(posedge clock) disable iff (rst)
      (cmd_valid && cmd_ready && (cmd_addr == 8'h00 || cmd_addr > 8'hF7))
        |=> done && fail_addr ##1 cmd_ready && !tx_valid;
  endproperty
  a_addr_refuse: assert property (p_addr_refuse) else $error("bad address sent");

  property p_rtu_gap;
    @(posedge clock) disable iff (rst)
      (q.st == mbm_pkg::s_rbody && !q.ascii && !rx_valid && q.timer >= RTU_GAP_CYC)
        |=> done ##1 !done;
  endproperty
  a_rtu_gap: assert property (p_rtu_gap) else $error("binary frame not closed");

  property p_reg_offset;
    @(posedge clock) disable iff (rst)
      (cmd_valid && cmd_ready && cmd_addr == 8'h11)
        |=> q.regn == $past(cmd_reg) - 16'h0001;
  endproperty
  a_reg_offset: assert property (p_reg_offset) else $error("register offset");

endmodule // mbm_master

`default_nettype wire

// >>> core/mbm_pkg.sv
/*
  Types of the serial bus master: states and the state records
  of each module. Assumes mbm_defines.svh is on the include path.
*/
`include "mbm_defines.svh"

package mbm_pkg;

  typedef enum logic [3:0] {
    s_idle, s_sof, s_body, s_chk, s_cr, s_lf, s_rwait, s_rbody, s_rlf
  } mbm_state_type;

  typedef struct packed {
    mbm_state_type          st;
    logic                   ascii;
    logic [7:0]             addr;
    logic [7:0]             func;
    logic [15:0]            regn;
    logic [15:0]            cnt;
    logic [7:0]             idx;
    logic                   nib;
    logic                   k;
    logic [15:0]            wbuf;
    logic                   have;
    logic [3:0]             hinib;
    logic [7:0]             hib;
    logic [7:0]             ri;
    logic [7:0]             bcnt;
    logic                   exc;
    logic                   abad;
    logic [7:0]             ecode;
    logic [`MBM_TMR_W-1:0]  timer;
    logic                   done;
    logic                   f_chk;
    logic                   f_addr;
    logic                   f_tmo;
    logic                   f_exc;
  } mbm_main_type;

  typedef struct packed {
    logic [7:0]  sum;
    logic [15:0] crc;
  } mbm_chk_type;

  typedef struct packed {
    logic [1:0][15:0] d;
    logic [1:0]       cnt;
  } mbm_buf_type;

endpackage

// >>> test/mbm_slave_model.sv
/*
  Behavioural slave device: collects binary request frames and answers.
  Assumes one character per handshake from the master, tx_ready held high.
*/
`timescale 1ns/1ps
`default_nettype none

module mbm_slave_model (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       corrupt,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data
);
  logic [7:0]  got[$];
  logic [7:0]  rep[$];
  logic        crc_ok;
  logic [15:0] c;
  int          idle;
  string       lrc_bad = ":1103FF\015\012";  // Text reply with a wrong check byte

  // Reflected CRC over the eight data bits of each byte
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] r;
    r = 16'hFFFF;
    foreach (b[i]) begin
      r = r ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
    end
    return r;
  endfunction

  assign tx_ready = 1'b1;

  // Answer after a quiet spell; released data line toggles
  always @(posedge clock) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h55;
      idle = 0;
      rep.delete();
    end else begin
      idle = tx_valid ? 0 : idle + 1;
      if (tx_valid) got.push_back(tx_data);
      if (rx_valid && rx_ready) void'(rep.pop_front());
      if (idle == 30 && got.size() > 7 && got[0] != 8'h3A) begin
        crc_ok = (crc16(got) == 16'h0000);
        if (crc_ok) begin
          rep = got[0:got.size()-3];
          if (got[1] == 8'h03) begin
            rep = got[0:1];
            if ({got[4], got[5]} > 16'h0020) begin
              rep[1] = rep[1] | 8'h80;
              rep.push_back(8'h03);
            end else begin
              rep.push_back({got[5][6:0], 1'b0});
              for (int i = 0; i < got[5]; i++) begin
                c = {got[2], got[3]} + 16'hC000 + 16'(i); // Fixed, writes never stick
                rep.push_back(c[15:8]);
                rep.push_back(c[7:0]);
              end
            end
          end
          c = crc16(rep) ^ {15'h0000, corrupt};
          rep.push_back(c[7:0]);
          rep.push_back(c[15:8]);
        end
      end
      if (idle == 30 && corrupt && got.size() > 0 && got[0] == 8'h3A) begin
        foreach (lrc_bad[i]) rep.push_back(lrc_bad[i]);
      end
      rx_valid <= rep.size() > 0;
      rx_data  <= rep.size() > 0 ? rep[0] : ~rx_data;
    end
  end
endmodule // mbm_slave_model

`default_nettype wire

// >>> test/modbus_slave_framer_bench.sv
/*
  Self-checking bench of the serial bus master against a slave model.
  Assumes the design files and test/mbm_slave_model.sv are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module modbus_slave_framer_bench;
  logic        clock, rst, cmd_valid, cmd_ready, cmd_ascii, rsp_ready, corrupt;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, rsp_valid, done;
  logic        f_chk, f_adr, f_tmo, exc, wr_valid, wr_ready;
  logic [7:0]  cmd_addr, cmd_func, tx_data, rx_data, exc_code;
  logic [15:0] cmd_reg, cmd_cnt, rsp_data, wr_data;
  logic [15:0] words[$];
  int          n_fail, num_checks;
  string       s;

  mbm_master #(.RESP_CYC(28'h00007D0), .ASCII_GAP_CYC(28'h00007D0),
    .RTU_GAP_CYC(28'h0000064)) mbm_master_inst (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_ascii(cmd_ascii), .cmd_addr(cmd_addr), .cmd_func(cmd_func), .cmd_reg(cmd_reg),
    .cmd_cnt(cmd_cnt), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .done(done), .fail_check(f_chk), .fail_addr(f_adr),
    .fail_timeout(f_tmo), .exception(exc), .exc_code(exc_code));

  mbm_slave_model mdl_inst (
    .clock(clock), .rst(rst), .corrupt(corrupt), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data));

  // Clock and read word capture
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) if (rsp_valid && rsp_ready) words.push_back(rsp_data);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One request, then wait for its done pulse
  task automatic run(input logic a, input logic [7:0] ad, fc, input logic [15:0] rg, ct,
                     output int n);
    @(posedge clock);
    #1;
    mdl_inst.got.delete();
    words.delete();
    cmd_ascii = a;
    cmd_addr  = ad;
    cmd_func  = fc;
    cmd_reg   = rg;
    cmd_cnt   = ct;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clock);
      #1 n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
  endtask

  task automatic t_frames();
    int n;
    run(1'b0, 8'h00, 8'h03, 16'h0001, 16'h0001, n);
    chk("bad address latency", 16'h0001, 16'(n));
    chk("bad address flag", 16'h0001, {15'h0000, f_adr});
    chk("bad address chars", 16'h0000, 16'(mdl_inst.got.size()));
    run(1'b1, 8'h05, 8'h03, 16'h0065, 16'h0002, n);
    s = ":05030064000292\015\012";
    chk("text length", 16'h0011, 16'(mdl_inst.got.size()));
    for (int i = 0; i < 17; i++) chk("text char", {8'h00, s[i]}, {8'h00, mdl_inst.got[i]});
    chk("no reply timeout", 16'h0001, {15'h0000, f_tmo});
  endtask

  // Read with the reader stalled so the buffer fills and drains
  task automatic t_read();
    int n;
    rsp_ready = 1'b0;
    fork
      run(1'b0, 8'h11, 8'h03, 16'h002B, 16'h0004, n);
      begin
        repeat (60) @(posedge clock);
        #1 rsp_ready = 1'b1;
      end
    join
    chk("request check", 16'h0001, {15'h0000, mdl_inst.crc_ok});
    chk("register field", 16'h002A, {mdl_inst.got[2], mdl_inst.got[3]});
    chk("read flags", 16'h0000, {12'h000, f_chk, f_adr, f_tmo, exc});
    chk("word count", 16'h0004, 16'(words.size()));
    foreach (words[i]) chk("read word", 16'hC02A + 16'(i), words[i]);
  endtask

  task automatic t_replies();
    int n;
    run(1'b0, 8'h11, 8'h03, 16'h0001, 16'h0021, n);
    chk("exception", 16'h0103, {7'h00, exc, exc_code});
    run(1'b0, 8'h11, 8'h06, 16'h0002, 16'h1234, n);
    chk("write echo", 16'h0000, {12'h000, f_chk, f_adr, f_tmo, exc});
    run(1'b0, 8'h11, 8'h08, 16'h0001, 16'hA55A, n);
    chk("loop echo", 16'h0000, {12'h000, f_chk, f_adr, f_tmo, exc});
    corrupt = 1'b1;
    run(1'b0, 8'h11, 8'h03, 16'h0001, 16'h0001, n);
    chk("bad check", 16'h0001, {15'h0000, f_chk});
    run(1'b1, 8'h11, 8'h03, 16'h0001, 16'h0001, n);
    chk("bad text check", 16'h0008, {12'h000, f_chk, f_adr, f_tmo, exc});
    corrupt = 1'b0;
  endtask

  // Multi-register write with two value words, then a read-back
  task automatic t_write();
    int n;
    wr_data  = 16'h1234;
    wr_valid = 1'b1;
    fork
      run(1'b0, 8'h11, 8'h10, 16'h0003, 16'h0002, n);
      begin
        @(posedge clock iff wr_ready);
        #1 wr_data = 16'h5678;
        @(posedge clock iff wr_ready);
        #1 wr_valid = 1'b0;
      end
    join
    chk("write byte count", 16'h0004, {8'h00, mdl_inst.got[6]});
    chk("write value 0", 16'h1234, {mdl_inst.got[7], mdl_inst.got[8]});
    chk("write value 1", 16'h5678, {mdl_inst.got[9], mdl_inst.got[10]});
    chk("write flags", 16'h0000, {12'h000, f_chk, f_adr, f_tmo, exc});
    run(1'b0, 8'h11, 8'h03, 16'h0003, 16'h0001, n);
    chk("read-only kept", 16'hC002, words[0]);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, cmd_valid, cmd_ascii, rsp_ready, corrupt, wr_valid} = 6'h24;
    {cmd_addr, cmd_func, cmd_reg, cmd_cnt, wr_data} = 64'h0;
    repeat (20) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock);
    #1;
    t_frames();
    t_read();
    t_replies();
    t_write();
    finish_test();
  end

  // Watchdog
  initial begin
    #300us;
    n_fail++;
    finish_test();
  end
endmodule // modbus_slave_framer_bench

`default_nettype wire
